// *** include/csu_pkg.sv ***
// Package for the clocked serial slave channel: register map, fields,
// reset values and the carrier types shared by the design and the bench.
// Assumes a 32-bit APB master on the same clock as the channel.
package csu_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] MODE_OFS   = 8'h00; // channel_mode_reg
  localparam logic [7:0] COMM_OFS   = 8'h04; // comm_setting_reg
  localparam logic [7:0] DATA_OFS   = 8'h08; // channel_data_reg
  localparam logic [7:0] STAT_OFS   = 8'h0C; // channel_status_reg
  localparam logic [7:0] OLVL_OFS   = 8'h10; // output_level_reg
  localparam logic [7:0] OEN_OFS    = 8'h14; // output_enable_reg
  localparam logic [7:0] START_OFS  = 8'h18; // channel start
  localparam logic [7:0] STOP_OFS   = 8'h1C; // channel_stop_reg
  localparam logic [7:0] ERRCLR_OFS = 8'h20; // overrun clear
  localparam logic [7:0] PCLK_OFS   = 8'h24; // peripheral_clock_enable
  localparam logic [7:0] PRESC_OFS  = 8'h28; // prescaler_select_reg

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned MODE_IRQSRC = 0;
  localparam int unsigned MODE_CKSEL  = 1;
  localparam int unsigned COMM_RXMODE = 0;
  localparam int unsigned COMM_LSB    = 1;
  localparam int unsigned COMM_LEN8   = 2;
  localparam int unsigned COMM_CKP    = 3;
  localparam int unsigned COMM_DAP    = 4;
  localparam int unsigned STAT_OVR    = 0;
  localparam int unsigned STAT_BFF    = 5;
  localparam int unsigned STAT_TSF    = 6;
  localparam int unsigned STAT_RUN    = 7;
  localparam int unsigned CH_BIT      = 0;
  localparam int unsigned PRE_W       = 8;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } csu_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } csu_apb_rsp_type;

  typedef struct packed {
    logic             per_en;
    logic [3:0]       div_a;
    logic [3:0]       div_b;
    logic             cks;
    logic             md;
    logic             rx_mode;
    logic             dap;
    logic             ckp;
    logic             lsb;
    logic             len8;
    logic [7:0]       tx_word;
    logic [7:0]       rx_word;
    logic             bff;
    logic             ovf;
    logic             run;
    logic             busy;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic [15:0]      oe_reg;
    logic             so_lvl;
    logic [1:0]       sck_sy;
    logic [1:0]       si_sy;
    logic             sck_s;
    logic [PRE_W-1:0] pre;
    csu_apb_rsp_type  rsp;
    logic             so;
    logic             so_oe;
    logic             irq;
  } csu_state_type;

  localparam csu_state_type CSU_STATE_RST = '{
    per_en: 1'h1, len8: 1'h1, sck_sy: 2'h3, sck_s: 1'h1, default: '0};

endpackage

// *** src/csu_slave.sv ***
// Clocked serial channel working as slave transmitter or slave receiver,
// with its registers behind an APB slave port.
// Assumes an external master drives the serial clock at most operation clock tick/6.
//
// Behaviour
// - Transmit shifts out only on externally supplied serial clock edges.
// - Receive shifts data in; output level and enable are unused then.
// - Transmit interrupt is either transfer end or buffer empty.
// - Overrun is the only error, shown in its own status flag.
// - Word length is 7 or 8 bits.
// - Serial clock sampled by operation clock; master stays below fmck/6.
// - Data phase 0 drives first bit at clocking start, 1 half earlier.
// - Data phase moves receive sampling the same way.
// - Clock polarity 0 uses the serial clock as is, 1 inverts it.
// - Direction bit selects MSB first or LSB first.
// - Clock select picks prescaled clock a (0) or b (1).
// - Interrupt source bit: 0 transfer end, 1 buffer empty.
// - Low 8 data register bits are the serial data port.
// - Writing while buffer full replaces the buffered word.
// - Interrupt source may change during operation, before the last bit.
// - Writing 1 to the channel start bit starts only this channel.
// - Writing 1 to the stop bit clears the running status.
// - Output enable 0 stops driving the data output pin.
// - Removing the unit clock supply resets the whole unit except the bus answer.
// - Start bit sets running status to 1.
`timescale 1ns/10ps
module csu_slave (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire csu_pkg::csu_apb_req_type apb_req,
  output      csu_pkg::csu_apb_rsp_type apb_rsp,
  input  wire logic                     slave_clock_pin,
  input  wire logic                     slave_data_in_pin,
  output      logic                     slave_data_out_pin,
  output      logic                     slave_data_out_oe,
  output      logic                     channel_irq
);
  import csu_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic tx_bit(logic [7:0] v, logic lsb, logic len8);
    return lsb ? v[0] : (len8 ? v[7] : v[6]);
  endfunction

  function automatic logic [7:0] tx_shift(logic [7:0] v, logic lsb);
    return lsb ? {1'h0, v[7:1]} : {v[6:0], 1'h0};
  endfunction

  csu_state_type    s_q;
  csu_state_type    s_d;
  logic             done;
  logic             wr;
  logic             rd;
  logic [PRE_W-1:0] mask_a;
  logic [PRE_W-1:0] mask_b;
  logic             tick;
  logic             eff_old;
  logic             eff_new;
  logic             rise;
  logic             fall;
  logic             samp;
  logic             shft;
  logic [3:0]       len;
  logic [7:0]       sh_in;
  logic             word_end;
  logic             tx_load;
  logic [31:0]      rdata;
  logic             hit;

  // ------------------------------------------------------------------
  // Bus decode and edge detection
  // ------------------------------------------------------------------
  assign done = apb_req.psel & apb_req.penable & s_q.rsp.pready;
  assign wr   = done & apb_req.pwrite;
  assign rd   = done & ~apb_req.pwrite;
  assign mask_a = ~({PRE_W{1'h1}} << s_q.div_a);
  assign mask_b = ~({PRE_W{1'h1}} << s_q.div_b);
  // Operation clock is a tick from one of the two prescaler taps
  assign tick = s_q.cks ? ((s_q.pre & mask_b) == mask_b)
                        : ((s_q.pre & mask_a) == mask_a);
  // Edges are only seen at operation clock ticks, hence the fmck/6 limit
  assign eff_old = s_q.sck_s ^ s_q.ckp;
  assign eff_new = s_q.sck_sy[1] ^ s_q.ckp;
  assign rise = s_q.run & tick & ~eff_old & eff_new;
  assign fall = s_q.run & tick & eff_old & ~eff_new;
  assign samp = s_q.dap ? fall : rise;
  assign shft = s_q.dap ? rise : fall;
  assign len  = s_q.len8 ? 4'h8 : 4'h7;
  assign sh_in = s_q.lsb ? {s_q.si_sy[1], s_q.sh[7:1]}
                         : {s_q.sh[6:0], s_q.si_sy[1]};
  assign word_end = samp & (s_q.busy | s_q.rx_mode)
                  & ((s_q.cnt + 4'h1) == len);
  // With data phase 1 the first bit goes out before any clock edge
  assign tx_load = s_q.run & ~s_q.rx_mode & ~s_q.busy
                 & (s_q.dap ? s_q.bff : fall);

  // ------------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'h1;
    unique case (apb_req.paddr)
      MODE_OFS: begin
        rdata[MODE_IRQSRC] = s_q.md;
        rdata[MODE_CKSEL]  = s_q.cks;
      end
      COMM_OFS: begin
        rdata[COMM_RXMODE] = s_q.rx_mode;
        rdata[COMM_LSB]    = s_q.lsb;
        rdata[COMM_LEN8]   = s_q.len8;
        rdata[COMM_CKP]    = s_q.ckp;
        rdata[COMM_DAP]    = s_q.dap;
      end
      DATA_OFS:
        rdata[7:0] = s_q.rx_mode ? s_q.rx_word : s_q.tx_word;
      STAT_OFS: begin
        rdata[STAT_OVR] = s_q.ovf;
        rdata[STAT_BFF] = s_q.bff;
        rdata[STAT_TSF] = s_q.busy;
        rdata[STAT_RUN] = s_q.run;
      end
      OLVL_OFS:   rdata[0]    = s_q.so_lvl;
      OEN_OFS:    rdata[15:0] = s_q.oe_reg;
      START_OFS:  rdata       = 32'h0000_0000;
      STOP_OFS:   rdata       = 32'h0000_0000;
      ERRCLR_OFS: rdata       = 32'h0000_0000;
      PCLK_OFS:   rdata[0]    = s_q.per_en;
      PRESC_OFS:  rdata[7:0]  = {s_q.div_b, s_q.div_a};
      default:    hit         = 1'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'h0;
    s_d.sck_sy = {s_q.sck_sy[0], slave_clock_pin};
    s_d.si_sy  = {s_q.si_sy[0], slave_data_in_pin};
    s_d.pre = s_q.pre + {{(PRE_W-1){1'h0}}, 1'h1};
    if (tick) begin
      s_d.sck_s = s_q.sck_sy[1];
    end
    // Bus answer: one wait state, read data ready with pready
    s_d.rsp.pready  = apb_req.psel & apb_req.penable & ~s_q.rsp.pready;
    s_d.rsp.prdata  = (apb_req.pwrite | ~hit) ? 32'h0000_0000 : rdata;
    s_d.rsp.pslverr = s_d.rsp.pready & ~hit;
    // Shift engine
    if (tx_load) begin
      s_d.sh   = s_q.bff ? s_q.tx_word : s_q.sh;
      s_d.busy = 1'h1;
      s_d.cnt  = 4'h0;
      s_d.bff  = 1'h0;
      s_d.irq  = s_q.md & s_q.bff;
    end else if (shft & s_q.busy & ~s_q.rx_mode) begin
      s_d.sh = tx_shift(s_q.sh, s_q.lsb);
    end
    if (samp & (s_q.busy | s_q.rx_mode)) begin
      s_d.cnt  = s_q.cnt + 4'h1;
      s_d.busy = 1'h1;
      if (s_q.rx_mode) begin
        s_d.sh = sh_in;
      end
      if (word_end) begin
        s_d.busy = 1'h0;
        s_d.cnt  = 4'h0;
        // Source bit read live, so a late change still steers this word
        s_d.irq  = s_q.rx_mode | ~s_q.md;
      end
    end
    // Register writes and read side effects
    if (wr) begin
      unique case (apb_req.paddr)
        MODE_OFS: begin
          s_d.md  = apb_req.pwdata[MODE_IRQSRC];
          s_d.cks = apb_req.pwdata[MODE_CKSEL];
        end
        COMM_OFS: begin
          s_d.rx_mode = apb_req.pwdata[COMM_RXMODE];
          s_d.lsb     = apb_req.pwdata[COMM_LSB];
          s_d.len8    = apb_req.pwdata[COMM_LEN8];
          s_d.ckp     = apb_req.pwdata[COMM_CKP];
          s_d.dap     = apb_req.pwdata[COMM_DAP];
        end
        DATA_OFS:
          if (!s_q.rx_mode) begin
            s_d.tx_word = apb_req.pwdata[7:0];
            s_d.bff     = 1'h1;
          end
        OLVL_OFS: s_d.so_lvl = apb_req.pwdata[0];
        OEN_OFS:  s_d.oe_reg = apb_req.pwdata[15:0];
        START_OFS:
          if (apb_req.pwdata[CH_BIT]) begin
            s_d.run = 1'h1;
          end
        STOP_OFS:
          if (apb_req.pwdata[CH_BIT]) begin
            s_d.run  = 1'h0;
            s_d.busy = 1'h0;
            s_d.cnt  = 4'h0;
          end
        ERRCLR_OFS:
          if (apb_req.pwdata[STAT_OVR]) begin
            s_d.ovf = 1'h0;
          end
        PCLK_OFS:  s_d.per_en = apb_req.pwdata[0];
        PRESC_OFS: {s_d.div_b, s_d.div_a} = apb_req.pwdata[7:0];
        default: ;
      endcase
    end
    if (rd && apb_req.paddr == DATA_OFS && s_q.rx_mode) begin
      s_d.bff = 1'h0;
    end
    // Capture after the clears, so a completing word is never lost
    if (word_end & s_q.rx_mode) begin
      s_d.rx_word = s_q.len8 ? sh_in
                  : (s_q.lsb ? {1'h0, sh_in[7:1]} : {1'h0, sh_in[6:0]});
      s_d.bff     = 1'h1;
      if (s_q.bff) begin
        s_d.ovf = 1'h1;
      end
    end
    // Pin drive, from the next shifter so bit and flop line up
    s_d.so = (s_d.busy & ~s_q.rx_mode) ? tx_bit(s_d.sh, s_q.lsb, s_q.len8)
                                       : s_q.so_lvl;
    s_d.so_oe = s_q.oe_reg[CH_BIT] & ~s_q.rx_mode;
    // Unit without clock supply: everything back to reset but the bus
    if (!s_q.per_en) begin
      s_d        = CSU_STATE_RST;
      s_d.per_en = wr && apb_req.paddr == PCLK_OFS ? apb_req.pwdata[0]
                                                   : 1'h0;
      s_d.rsp    = '{pready: apb_req.psel & apb_req.penable
                             & ~s_q.rsp.pready,
                     prdata: (apb_req.pwrite | ~hit) ? 32'h0000_0000
                                                     : rdata,
                     pslverr: apb_req.psel & apb_req.penable
                              & ~s_q.rsp.pready & ~hit};
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= CSU_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp            = s_q.rsp;
  assign slave_data_out_pin = s_q.so;
  assign slave_data_out_oe  = s_q.so_oe;
  assign channel_irq        = s_q.irq;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_RUN: assert property (
    wr && apb_req.paddr == START_OFS && apb_req.pwdata[CH_BIT] && s_q.per_en
    |=> s_q.run)
    else $error("start write did not set running");

  AST_STOP_RUN: assert property (
    wr && apb_req.paddr == STOP_OFS && apb_req.pwdata[CH_BIT]
    |=> !s_q.run && !s_q.busy)
    else $error("stop write did not halt channel");

  AST_RX_NO_DRIVE: assert property (
    s_q.rx_mode && s_q.per_en |=> !slave_data_out_oe)
    else $error("data output driven in receive mode");

  AST_OE_OFF: assert property (
    !s_q.oe_reg[CH_BIT] |=> !slave_data_out_oe)
    else $error("data output driven while disabled");

  AST_OVR_SET: assert property (
    word_end && s_q.rx_mode && s_q.bff && s_q.per_en |=> s_q.ovf)
    else $error("overrun not flagged");

  AST_OVR_HOLD: assert property (
    s_q.ovf && s_q.per_en && !(wr && apb_req.paddr == ERRCLR_OFS)
    |=> s_q.ovf)
    else $error("overrun flag dropped without clear");

  AST_OVERWRITE: assert property (
    wr && apb_req.paddr == DATA_OFS && !s_q.rx_mode && s_q.per_en
    |=> s_q.bff && s_q.tx_word == $past(apb_req.pwdata[7:0]))
    else $error("transmit buffer not replaced");

  AST_END_IRQ: assert property (
    word_end && !s_q.rx_mode && !s_q.md && s_q.per_en |=> channel_irq)
    else $error("transfer end event missing");

  AST_PER_RESET: assert property (
    !s_q.per_en |=> !s_q.run && !s_q.busy && !s_q.bff)
    else $error("unit not reset without clock supply");

  AST_LEN: assert property (
    s_q.busy |-> s_q.cnt < len)
    else $error("bit count beyond word length");

  AST_SYNC_PATH: assert property (
    s_q.per_en && $past(s_q.per_en)
    |-> s_q.sck_sy == {$past(s_q.sck_sy[0]), $past(slave_clock_pin)})
    else $error("serial clock bypassed its synchroniser");

  AST_STOPPED_IDLE: assert property (
    !s_q.run |=> !s_q.busy)
    else $error("stopped channel started a word");

  AST_RX_CAPTURE: assert property (
    word_end && s_q.rx_mode && s_q.per_en |=> s_q.bff && channel_irq)
    else $error("received word not stored or not signalled");

  AST_ERR_UNMAPPED: assert property (
    apb_rsp.pready |-> apb_rsp.pslverr == !hit)
    else $error("bus error response does not match address decode");

  // ------------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------------
  COV_RX_WORD:  cover property (word_end && s_q.rx_mode);
  COV_TX_EMPTY: cover property (tx_load && s_q.md && s_q.bff);
  COV_OVERRUN:  cover property (!s_q.ovf ##1 s_q.ovf);
  COV_EARLY:    cover property (tx_load && s_q.dap);
  COV_LSB_WORD: cover property (word_end && s_q.lsb);
endmodule

// *** test/csu_spi_master.sv ***
// Serial master model that clocks the slave channel and swaps one word.
// Assumes xfer is called just after a pclk edge, with the channel
// configured for the same polarity, phase, length and bit order.
`timescale 1ns/10ps
module csu_spi_master (
  input  wire logic pclk,
  input  wire logic ckp,
  output      logic sck,
  output      logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic eff;
  // Pin level is the effective clock, inverted when polarity is set
  assign sck = eff ^ ckp;
  initial begin
    eff = 1'b1;
    mosi = 1'b0;
  end
  // ------------------------------------------------------------------
  // One word; half period h in pclk cycles, never below 3 ticks
  // ------------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input int n, input logic lsb,
                      input logic dap, input int h,
                      output logic [7:0] rx);
    int b;
    rx = 8'h00;
    for (int k = 0; k < n; k++) begin
      b = lsb ? k : n - 1 - k;
      if (!dap) begin
        eff <= 1'b0;
      end
      mosi <= tx[b];
      repeat (h) @(posedge pclk);
      rx[b] = miso_oe ? miso : 1'bx;
      eff <= dap ? 1'b0 : 1'b1;
      repeat (h) @(posedge pclk);
      if (dap) begin
        eff <= 1'b1;
      end
    end
    // Released data line must not keep the last bit
    mosi <= ~mosi;
    repeat (h) @(posedge pclk);
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the serial slave channel and its APB registers.
// Assumes the master model on the far side and a 100 MHz pclk.
`timescale 1ns/10ps
module tb;
  import csu_pkg::*;
  logic            pclk;
  logic            presetn;
  csu_apb_req_type req;
  csu_apb_rsp_type rsp;
  logic            sck;
  logic            mosi;
  logic            so;
  logic            so_oe;
  logic            irq;
  logic            ckp_m;
  int              n_errors;
  int              compares;
  int              n_irq;
  int              cyc;
  int              k;
  int              nb;
  logic [31:0]     rd;
  logic            err;
  logic [7:0]      got;
  logic [7:0]      w;
  logic [7:0]      msk;
  logic [4:0]      cfg;

  csu_slave csu_slave_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .slave_clock_pin(sck), .slave_data_in_pin(mosi),
    .slave_data_out_pin(so), .slave_data_out_oe(so_oe),
    .channel_irq(irq));
  csu_spi_master csu_spi_master_inst (
    .pclk(pclk), .ckp(ckp_m), .sck(sck), .mosi(mosi), .miso(so),
    .miso_oe(so_oe));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // Irq is a one-cycle pulse, so it is counted at every edge
  always @(posedge pclk) begin
    cyc++;
    if (irq === 1'b1) begin
      n_irq++;
    end
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // Stop first so the polarity swap on the pin is not taken as an edge
  task automatic setup(input logic [4:0] c);
    wr(STOP_OFS, 32'h1);
    ckp_m <= c[2];
    wr(COMM_OFS, {27'h0, c[3:0], c[4]});
    wr(MODE_OFS, {30'h0, c[0], 1'b0});
    wr(OEN_OFS, 32'h1);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    req = '0;
    ckp_m = 1'b0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'({so, so_oe, irq}), 32'h0);
    rchk(COMM_OFS, 32'h4);
    rchk(STAT_OFS, 32'h0);
    rchk(PCLK_OFS, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check(32'(err), 32'h1);
    wr(START_OFS, 32'hFFFE);
    rchk(STAT_OFS, 32'h0);
    // Clock b ticks every second pclk, half period 10 stays legal
    wr(PRESC_OFS, 32'h10);
    for (int i = 0; i < 32; i++) begin
      cfg = 5'(i);
      nb = cfg[1] ? 8 : 7;
      msk = cfg[1] ? 8'hFF : 8'h7F;
      w = 8'hC3 + 8'(i * 37);
      setup(cfg);
      if (!cfg[4]) begin
        wr(DATA_OFS, {24'h0, w});
      end
      wr(START_OFS, 32'h1);
      // Data phase 1 loads the buffered word as soon as the channel runs
      rchk(STAT_OFS, cfg[4] ? 32'h80
                            : (cfg[3] ? 32'hC0 : 32'hA0));
      k = n_irq;
      csu_spi_master_inst.xfer(w, nb, cfg[0], cfg[3], 10, got);
      check(32'(n_irq - k), 32'h1);
      if (cfg[4]) begin
        rchk(DATA_OFS, {24'h0, w & msk});
      end else begin
        check({24'h0, got}, {24'h0, w & msk});
      end
      rchk(STAT_OFS, 32'h80);
    end
    // Two words unread in receive mode, at the slow clock
    setup(5'h12);
    wr(START_OFS, 32'h1);
    csu_spi_master_inst.xfer(8'h3C, 8, 1'b0, 1'b0, 20, got);
    csu_spi_master_inst.xfer(8'h96, 8, 1'b0, 1'b0, 20, got);
    rchk(STAT_OFS, 32'hA1);
    wr(ERRCLR_OFS, 32'h1);
    rchk(STAT_OFS, 32'hA0);
    rchk(DATA_OFS, 32'h96);
    // Buffer-empty source, buffered word replaced before start
    setup(5'h02);
    wr(MODE_OFS, 32'h1);
    wr(DATA_OFS, 32'h11);
    wr(DATA_OFS, 32'h5A);
    wr(START_OFS, 32'h1);
    k = n_irq;
    csu_spi_master_inst.xfer(8'h00, 8, 1'b0, 1'b0, 10, got);
    check({24'h0, got}, 32'h5A);
    check(32'(n_irq - k), 32'h1);
    // Source switched to transfer end while the word is shifting
    wr(DATA_OFS, 32'hA5);
    k = n_irq;
    fork
      csu_spi_master_inst.xfer(8'h00, 8, 1'b0, 1'b0, 10, got);
      begin
        repeat (40) @(posedge pclk);
        wr(MODE_OFS, 32'h0);
      end
    join
    check(32'(n_irq - k), 32'h2);
    check({24'h0, got}, 32'hA5);
    // Stopped channel ignores the clock; idle output shows the level
    wr(STOP_OFS, 32'h1);
    rchk(STAT_OFS, 32'h0);
    k = n_irq;
    csu_spi_master_inst.xfer(8'hFF, 8, 1'b0, 1'b0, 10, got);
    check(32'(n_irq - k), 32'h0);
    wr(OLVL_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'({so_oe, so}), 32'h3);
    wr(OEN_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(so_oe), 32'h0);
    // Removing the unit clock restores every register
    wr(COMM_OFS, 32'h1F);
    wr(PCLK_OFS, 32'h0);
    wr(PCLK_OFS, 32'h1);
    rchk(COMM_OFS, 32'h4);
    rchk(OLVL_OFS, 32'h0);
    complete_run();
  end
endmodule
